/* hdl/pstid_pkg.sv */
package pstid_pkg;
  // management register addresses (5-bit phy register index)
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] REG_IDENT_ONE = 5'h02;
  localparam logic [4:0] REG_LINK_PARTNER = 5'h05;
  // basic status field positions
  localparam int BIT_CAP_100TX_FD = 14;
  localparam int BIT_CAP_100TX_HD = 13;
  localparam int BIT_CAP_10T_FD = 12;
  localparam int BIT_CAP_10T_HD = 11;
  localparam int BIT_NO_PREAMBLE = 6;
  localparam int BIT_ANEG_DONE = 5;
  localparam int BIT_REMOTE_FAULT = 4;
  localparam int BIT_ANEG_ABLE = 3;
  localparam int BIT_LINK_UP = 2;
  localparam int BIT_JABBER = 1;
  localparam int BIT_EXT_CAP = 0;
  // remote fault position inside the link partner ability word
  localparam int BIT_LP_REMOTE_FAULT = 13;
  // fixed capability values
  localparam logic CAP_ANEG_ABLE = 1'b1;
  localparam logic CAP_EXT = 1'b1;
  localparam logic CAP_NO_PREAMBLE = 1'b1;
  localparam logic CAP_SPEED_BITS = 1'b1;
  // latched status reset values
  localparam logic RST_REMOTE_FAULT = 1'b0;
  localparam logic RST_LINK_UP = 1'b0;
  localparam logic RST_JABBER = 1'b0;
  // arbitrary neutral 24-bit unique identifier, not any real vendor's
  localparam logic [23:0] DEF_VENDOR_ID = 24'h5A5A5A;
endpackage

/* hdl/pstid_latch_low.sv */
`timescale 1ns/10ps
`default_nettype none
// sticky flag: event sets, read clears; set beats clear in the same cycle
module pstid_latch_low #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag_q
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= RST_VAL;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (clr_evt) begin
      flag_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* hdl/pstid_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module pstid_regs #(
  parameter logic [23:0] VENDOR_ID = pstid_pkg::DEF_VENDOR_ID
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_valid,
  input wire logic [15:0] link_partner_ability_reg,
  input wire logic link_ok,
  input wire logic speed_10m,
  input wire logic jabber_seen,
  input wire logic aneg_done,
  output logic mgmt_no_preamble_accept
);
  logic rd_accept;
  logic status_rd;
  logic remote_fault_flag;
  logic jabber_q;
  logic link_fail_q;
  logic link_evt;
  logic jab_evt;
  logic [15:0] status_word;
  logic [15:0] ident_word;
  logic [15:0] rd_data_d;

  // register index decodes; the status one is shared by the latch clear and the read mux
  function automatic logic is_status_addr(input logic [4:0] addr);
    return addr == pstid_pkg::REG_BASIC_STATUS;
  endfunction

  function automatic logic is_ident_addr(input logic [4:0] addr);
    return addr == pstid_pkg::REG_IDENT_ONE;
  endfunction

  // a write in the same cycle cancels the read, so it may not clear a latch either
  assign rd_accept = rd_en && !wr_en;
  // only an accepted read of the status word clears the latched bits
  assign status_rd = rd_accept && is_status_addr(reg_addr);
  // jabber is meaningless at 100 Mbps so it is gated here
  assign jab_evt = jabber_seen && speed_10m;
  assign link_evt = !link_ok;

  // writes are not routed to any latch, so they cannot clear one
  pstid_latch_low #(.RST_VAL(pstid_pkg::RST_REMOTE_FAULT)) u_rf (
    .clk(clk),
    .resetn(resetn),
    .set_evt(link_partner_ability_reg[pstid_pkg::BIT_LP_REMOTE_FAULT]),
    .clr_evt(status_rd),
    .flag_q(remote_fault_flag)
  );

  pstid_latch_low #(.RST_VAL(pstid_pkg::RST_JABBER)) u_jab (
    .clk(clk),
    .resetn(resetn),
    .set_evt(jab_evt),
    .clr_evt(status_rd),
    .flag_q(jabber_q)
  );

  // failure latch; reset starts as failed so the first read shows link down
  pstid_latch_low #(.RST_VAL(~pstid_pkg::RST_LINK_UP)) u_link (
    .clk(clk),
    .resetn(resetn),
    .set_evt(link_evt),
    .clr_evt(status_rd),
    .flag_q(link_fail_q)
  );

  // status word assembly; unlisted bits read zero
  always_comb begin
    status_word = 16'h0000;
    status_word[pstid_pkg::BIT_CAP_100TX_FD] = pstid_pkg::CAP_SPEED_BITS;
    status_word[pstid_pkg::BIT_CAP_100TX_HD] = pstid_pkg::CAP_SPEED_BITS;
    status_word[pstid_pkg::BIT_CAP_10T_FD] = pstid_pkg::CAP_SPEED_BITS;
    status_word[pstid_pkg::BIT_CAP_10T_HD] = pstid_pkg::CAP_SPEED_BITS;
    status_word[pstid_pkg::BIT_NO_PREAMBLE] = pstid_pkg::CAP_NO_PREAMBLE;
    status_word[pstid_pkg::BIT_ANEG_DONE] = aneg_done;
    status_word[pstid_pkg::BIT_REMOTE_FAULT] = remote_fault_flag;
    status_word[pstid_pkg::BIT_ANEG_ABLE] = pstid_pkg::CAP_ANEG_ABLE;
    status_word[pstid_pkg::BIT_LINK_UP] = link_ok && !link_fail_q;
    status_word[pstid_pkg::BIT_JABBER] = jabber_q;
    status_word[pstid_pkg::BIT_EXT_CAP] = pstid_pkg::CAP_EXT;
  end

  // id bits numbered 1..24 from msb; word one takes bits 3..18
  assign ident_word = VENDOR_ID[21:6];

  // the management receiver needs no preamble ahead of a frame
  assign mgmt_no_preamble_accept = pstid_pkg::CAP_NO_PREAMBLE;

  // read mux; writes land nowhere
  always_comb begin
    rd_data_d = 16'h0000;
    if (is_status_addr(reg_addr)) begin
      rd_data_d = status_word;
    end else if (is_ident_addr(reg_addr)) begin
      rd_data_d = ident_word;
    end
  end

  // valid pulse for one cycle per accepted read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_accept;
    end
  end

  // read data holds until the next accepted read; wr_data deliberately unused
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 16'h0000;
    end else if (rd_accept) begin
      rd_data <= rd_data_d;
    end
  end

  logic unused_wr;
  assign unused_wr = ^wr_data;
endmodule
`default_nettype wire

/* test/pstid_props.sv */
`timescale 1ns/10ps
`default_nettype none
// watches the status and ident read path from the top ports only
module pstid_props #(parameter logic [23:0] VENDOR_ID = 24'h000000) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic link_ok,
  input wire logic speed_10m,
  input wire logic jabber_seen,
  input wire logic rd_valid,
  input wire logic mgmt_no_preamble_accept,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] rd_data,
  input wire logic [15:0] link_partner_ability_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // a write in the same cycle cancels the read
  wire st = rd_en && !wr_en && reg_addr == 5'h01;
  wire id = rd_en && !wr_en && reg_addr == 5'h02;
  AST_ANEG_ABLE: assert property (st |=> rd_data[3]) else $error("aneg ability low");
  AST_EXT_CAP: assert property (st |=> rd_data[0]) else $error("ext cap low");
  AST_NO_PRE_BIT: assert property (st |=> rd_data[6]) else $error("preamble bit low");
  AST_NO_PRE_PIN: assert property (mgmt_no_preamble_accept) else $error("preamble pin low");
  AST_IDENT: assert property (id |=> rd_data == VENDOR_ID[21:6]) else $error("ident wrong");
  AST_JABBER: assert property (speed_10m && jabber_seen ##1 !rd_en ##1 st |=> rd_data[1]) else $error("jab");
  AST_RFAULT: assert property (link_partner_ability_reg[13] ##1 !rd_en ##1 st |=> rd_data[4]) else $error("rf");
  AST_LINK: assert property (!link_ok ##1 !rd_en ##1 st |=> !rd_data[2]) else $error("link not latched");
  AST_WRITE: assert property (wr_en |=> !rd_valid && $stable(rd_data)) else $error("write acted");
  cover property (st ##1 rd_valid);
  cover property (!link_ok ##1 link_ok);
  cover property (wr_en);
endmodule
`default_nettype wire

/* test/pstid_lp_model.sv */
`timescale 1ns/10ps
`default_nettype none
// far partner ability word, one cycle late like a received page
module pstid_lp_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fault,
  output logic [15:0] lpa
);
  // only the fault bit is modelled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lpa <= 16'h0000;
    else lpa <= {2'h0, fault, 13'h0000};
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {logic [4:0] a; logic [3:0] ev; logic [15:0] e;} pstid_row_t;
  logic clk = 0, resetn = 0, rd_en = 0, wr_en = 0, link = 1, spd = 1, jab = 0, rf = 0, rvalid, nopre;
  logic [4:0] addr = 5'h00;
  logic [15:0] wd = 16'h0000, lpa, rdata;
  int num_errors = 0, num_checks = 0;
  localparam logic [15:0] ID = pstid_pkg::DEF_VENDOR_ID[21:6];
  // ev: fault, jabber, 10M, link drop; first row sees the reset link latch
  pstid_row_t rows [10] = '{'{5'h01, 4'h0, 16'h7849}, '{5'h01, 4'h0, 16'h784D}, '{5'h02, 4'h0, ID},
    '{5'h01, 4'h8, 16'h785D}, '{5'h01, 4'h0, 16'h784D}, '{5'h01, 4'h6, 16'h784F}, '{5'h01, 4'h0, 16'h784D},
    '{5'h01, 4'h4, 16'h784D}, '{5'h01, 4'h1, 16'h7849}, '{5'h03, 4'h0, 16'h0000}};
  pstid_regs i_dut (.clk(clk), .resetn(resetn), .rd_en(rd_en), .wr_en(wr_en), .reg_addr(addr), .wr_data(wd),
    .rd_data(rdata), .rd_valid(rvalid), .link_partner_ability_reg(lpa), .link_ok(link), .speed_10m(spd),
    .jabber_seen(jab), .aneg_done(1'b0), .mgmt_no_preamble_accept(nopre));
  pstid_lp_model i_lp (.clk(clk), .resetn(resetn), .fault(rf), .lpa(lpa));
  task chk(input logic [16:0] s, input logic [16:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task final_report;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one read, answer looked at in its single valid cycle
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk) rd_en <= 1;
    addr <= a;
    @(posedge clk) rd_en <= 0;
    #1 chk({rvalid, rdata}, {1'b1, e});
  endtask
  // pulse fault, jabber and link drop for two cycles, then back to a quiet line; 10M keeps its new value
  task ev(input logic [3:0] v);
    @(posedge clk) {rf, jab, spd} <= v[3:1];
    link <= !v[0];
    repeat (2) @(posedge clk);
    {rf, jab, link} <= 3'b001;
  endtask
  initial forever #2 clk = ~clk;
  initial begin
    #4000 num_errors++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1;
    foreach (rows[i]) begin
      ev(rows[i].ev);
      rd(rows[i].a, rows[i].e);
    end
    chk({16'h0000, nopre}, 17'h00001);
    // latched jabber must survive writes, even with a read raised alongside them
    ev(4'h6);
    @(posedge clk) {rd_en, wr_en, addr, wd} <= {2'h3, 5'h01, 16'hFFFF};
    @(posedge clk) addr <= 5'h02;
    @(posedge clk) {rd_en, wr_en} <= 2'h0;
    #1 chk({rvalid, rdata}, 17'h00000);
    rd(5'h01, 16'h784F);
    rd(5'h02, ID);
    // mid-run reset clears the remote fault latch and rearms the link latch
    ev(4'hA);
    @(posedge clk) resetn <= 0;
    #1 chk({rvalid, rdata}, 17'h00000);
    repeat (10) @(posedge clk);
    resetn <= 1;
    rd(5'h01, 16'h7849);
    final_report;
  end
endmodule
bind pstid_regs pstid_props #(.VENDOR_ID(VENDOR_ID)) i_props (.clk(clk), .resetn(resetn), .rd_en(rd_en),
  .wr_en(wr_en), .reg_addr(reg_addr), .rd_data(rd_data), .rd_valid(rd_valid), .link_ok(link_ok),
  .speed_10m(speed_10m), .jabber_seen(jabber_seen), .link_partner_ability_reg(link_partner_ability_reg),
  .mgmt_no_preamble_accept(mgmt_no_preamble_accept));
`default_nettype wire
